// file: bench/vai_bench.sv
/*
  Self-checking bench for vai_inserter.
  Assumes vai_monitor is bound and vai_sink plays the destination.
*/
`timescale 1ns/100ps
`define CHK(a, b) cmp(32'(a), 32'(b));
module video_ancillary_data_inserter_bench
  import vai_pkg::*;
;
  localparam logic [7:0] HAM [16] = '{8'h15, 8'h02, 8'h49, 8'h5e, 8'h64,
    8'h73, 8'h38, 8'h2f, 8'hd0, 8'hc7, 8'h8c, 8'h9b, 8'ha1, 8'hb6,
    8'hfd, 8'hea};
  logic       clock_i, sys_rst_i, vid_valid_i, vid_ready_o, vid_valid_o;
  logic       vid_ready_i, pay_valid_i, pay_last_i, pay_ready_o;
  logic       hdr_en_i, mode625_i, busy_o, slow, ten_bit, cur_a;
  logic [9:0] cur_ln;
  vai_vid_s   vid_i, vid_o;
  vai_vid_s   got[$], exp[$];
  vai_hdr_s   hdr_i;
  logic [7:0] pay_i, pkts;
  int         err_total, comparisons, pay_left;
  vai_inserter dut (.clock_i, .sys_rst_i, .vid_i, .vid_valid_i,
    .vid_ready_o, .vid_o, .vid_valid_o, .vid_ready_i, .pay_i,
    .pay_valid_i, .pay_last_i, .pay_ready_o, .hdr_i, .hdr_en_i,
    .ten_bit_i(ten_bit), .mode625_i, .busy_o);
  vai_sink sink (.clock_i, .sys_rst_i, .vid_i(vid_o),
    .vid_valid_i(vid_valid_o), .slow_i(slow), .vid_ready_o(vid_ready_i),
    .pkt_o(pkts));
  always @(posedge clock_i)
    if (vid_valid_o && vid_ready_i)
      got.push_back(vid_o);
  initial
  begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic cmp(input logic [31:0] a, input logic [31:0] b);
    comparisons++;
    if (a !== b)
    begin
      err_total++;
      $display("wrong value at %0t: %h %h", $time, a, b);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic [9:0] ln,
    input logic a);
    logic r;
    logic p;
    vid_i <= '{word: {b, 2'h0}, line: ln, anc: a};
    vid_valid_i <= 1'h1;
    r = 1'h0;
    p = 1'h0;
    while (r !== 1'h1)
    begin
      @(negedge clock_i);
      r = vid_ready_o;
      p = pay_ready_o;
      @(posedge clock_i);
    end
    // Drop valid after the last byte, else the free flag chains a packet
    if (p === 1'h1)
    begin
      pay_left--;
      if (pay_left == 0)
        pay_valid_i <= 1'h0;
    end
  endtask
  task automatic frame(input logic [9:0] ln, input logic a,
    input logic [7:0] f, input int n);
    cur_ln = ln;
    cur_a = a;
    @(posedge clock_i);
    put(8'h00, ln, a);
    put(8'hff, ln, a);
    put(8'hff, ln, a);
    put(f, ln, a);
    repeat (n) put(8'h10, ln, a);
    vid_valid_i <= 1'h0;
  endtask
  task automatic e10(input logic [9:0] w);
    exp.push_back('{word: w, line: cur_ln, anc: cur_a});
  endtask
  task automatic e8(input logic [7:0] b);
    e10({b, 2'h0});
  endtask
  task automatic pre(input logic [7:0] f);
    e8(VAI_PRE_ZERO);
    e8(VAI_PRE_ONES);
    e8(VAI_PRE_ONES);
    e8(f);
  endtask
  task automatic check();
    for (int k = 0; k < 40 && got.size() < exp.size(); k++)
      @(posedge clock_i);
    `CHK(got.size(), exp.size())
    foreach (exp[i])
      `CHK(got[i], exp[i])
    got.delete();
    exp.delete();
  endtask
  task automatic s_insert();
    slow <= 1'h1;
    pay_i <= 8'h09;
    pay_valid_i <= 1'h1;
    pay_left = 1;
    frame(10'd100, 1'h1, VAI_FLAG_FREE, 6);
    pre(HAM[1]);
    e8(HAM[9]);
    pre(VAI_FLAG_FREE);
    e8(8'h10);
    check();
    `CHK(pkts, 8'h01)
  endtask
  task automatic s_hdr8();
    logic [7:0] h [6] = '{HAM[5], HAM[10], HAM[3], HAM[12], HAM[1], HAM[6]};
    hdr_en_i <= 1'h1;
    pay_i <= 8'h06;
    pay_valid_i <= 1'h1;
    pay_left = 1;
    hdr_i <= '{typ: 12'h3a5, len: 8'h1c, ident: 8'h00, blkno: 8'h00};
    frame(10'd101, 1'h1, VAI_FLAG_FREE, 11);
    pre(HAM[1]);
    foreach (h[i])
      e8(h[i]);
    pre(VAI_FLAG_FREE);
    e8(8'h10);
    check();
  endtask
  // Parity pair per byte: bit 8 evens the low nine, bit 9 its inverse;
  // checksum is the nine-bit sum of header and payload with bit 9 inverted
  task automatic s_ten();
    ten_bit <= 1'h1;
    pay_i <= 8'h5a;
    pay_valid_i <= 1'h1;
    pay_left = 1;
    hdr_i <= '{typ: 12'h000, len: 8'h01, ident: 8'h41, blkno: 8'h02};
    frame(10'd102, 1'h1, VAI_FLAG_FREE, 10);
    pre(HAM[1]);
    e10(10'h241);
    e10(10'h102);
    e10(10'h101);
    e10(10'h25a);
    e10(10'h29e);
    pre(VAI_FLAG_FREE);
    e8(8'h10);
    check();
    ten_bit <= 1'h0;
  endtask
  task automatic s_reserved();
    logic [9:0] ln [5] = '{10'd20, 10'd333, 10'd23, 10'd623, 10'd100};
    slow <= 1'h0;
    pay_valid_i <= 1'h1;
    pay_left = 1;
    foreach (ln[i])
    begin
      frame(ln[i], 1'(i < 4), VAI_FLAG_FREE, 1);
      pre(VAI_FLAG_FREE);
      e8(8'h10);
    end
    // A packet already on the line keeps its flag and words
    frame(10'd101, 1'h1, HAM[1], 1);
    pre(HAM[1]);
    e8(8'h10);
    check();
    `CHK(pay_valid_i, 1'h1)
    // Same line without 625 mode takes two chained packets
    mode625_i <= 1'h0;
    hdr_en_i <= 1'h0;
    pay_i <= 8'h06;
    pay_left = 2;
    frame(10'd20, 1'h1, VAI_FLAG_FREE, 11);
    pre(HAM[1]);
    e8(HAM[6]);
    pre(HAM[1]);
    e8(HAM[6]);
    pre(VAI_FLAG_FREE);
    e8(8'h10);
    check();
    `CHK(pkts, 8'h06)
  endtask
  task automatic final_report();
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {sys_rst_i, mode625_i} = 2'h3;
    {vid_valid_i, pay_valid_i, pay_last_i, hdr_en_i, slow} = 5'h04;
    ten_bit = 1'h0;
    vid_i = '0;
    hdr_i = '0;
    pay_i = 8'h00;
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    s_insert();
    s_hdr8();
    s_ten();
    s_reserved();
    final_report();
  end
  // Whole run is under two hundred cycles; this 2000-cycle span is ample
  initial
  begin
    #20000;
    err_total++;
    final_report();
  end
endmodule

// file: bench/vai_monitor.sv
/*
  Port checker for vai_inserter.
  Assumes the bind below; watches ports only.
*/
`timescale 1ns/100ps
module vai_monitor
  import vai_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  input  wire vai_vid_s vid_i,
  input  wire logic     vid_valid_i,
  input  wire logic     vid_ready_o,
  input  wire vai_vid_s vid_o,
  input  wire logic     vid_valid_o,
  input  wire logic     vid_ready_i,
  input  wire logic     pay_valid_i,
  input  wire logic     pay_ready_o,
  input  wire logic     mode625_i,
  input  wire logic     busy_o
);
  logic [1:0] occ_reg;
  logic       take;
  logic       give;
  logic       rsv;
  assign take = vid_valid_i && vid_ready_o;
  assign give = vid_valid_o && vid_ready_i;
  assign rsv = mode625_i && (vid_i.line == VAI_LINE_EQP_A
    || vid_i.line == VAI_LINE_EQP_B || vid_i.line == VAI_LINE_ASP_A
    || vid_i.line == VAI_LINE_ASP_B);
  // Own count of buffered words, so a lost or doubled word shows up
  always_ff @(posedge clock_i)
    if (sys_rst_i)
      occ_reg <= 2'h0;
    else
      occ_reg <= occ_reg + 2'(take) - 2'(give);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_clear: assert property (disable iff (1'h0) sys_rst_i |=>
    !vid_valid_o && !busy_o) else $error("reset left outputs set");
  a_occ_valid: assert property (vid_valid_o == (occ_reg != 2'h0))
    else $error("valid does not match buffer fill");
  a_full_refuse: assert property (occ_reg == 2'h2 |-> !vid_ready_o)
    else $error("ready while buffer full");
  a_out_hold: assert property (vid_valid_o && !vid_ready_i |=>
    vid_valid_o && $stable(vid_o)) else $error("output changed in stall");
  a_pay_take: assert property (pay_ready_o |-> pay_valid_i && take)
    else $error("payload taken without word");
  a_pay_busy: assert property (pay_ready_o |-> busy_o)
    else $error("payload taken while scanning");
  a_reserved_idle: assert property (rsv && !busy_o |=> !busy_o)
    else $error("insertion on reserved line");
  a_blank_idle: assert property (!vid_i.anc && !busy_o |=> !busy_o)
    else $error("insertion outside ancillary area");
  c_pay: cover property (pay_ready_o);
  c_full: cover property (occ_reg == 2'h2);
  c_rsv: cover property (rsv && take);
endmodule

bind vai_inserter vai_monitor mon (.clock_i, .sys_rst_i, .vid_i,
  .vid_valid_i, .vid_ready_o, .vid_o, .vid_valid_o, .vid_ready_i,
  .pay_valid_i, .pay_ready_o, .mode625_i, .busy_o);

// file: bench/vai_sink.sv
/*
  Downstream video destination model: takes words, counts packets.
  Assumes one clock; slow_i makes it stall every other cycle.
*/
`timescale 1ns/100ps
module vai_sink
  import vai_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  input  wire vai_vid_s vid_i,
  input  wire logic     vid_valid_i,
  input  wire logic     slow_i,
  output logic          vid_ready_o,
  output logic [7:0]    pkt_o
);
  logic [23:0] hist_reg;
  logic        ph_reg;
  assign vid_ready_o = !slow_i || ph_reg;
  always_ff @(posedge clock_i)
    ph_reg <= sys_rst_i ? 1'h0 : !ph_reg;
  always_ff @(posedge clock_i)
    if (sys_rst_i)
    begin
      hist_reg <= 24'h0;
      pkt_o <= 8'h0;
    end
    else if (vid_valid_i && vid_ready_o)
    begin
      hist_reg <= {hist_reg[15:0], vid_i.word[9:2]};
      if (hist_reg == 24'h00ffff && vid_i.word[9:2] != VAI_FLAG_FREE)
        pkt_o <= pkt_o + 8'h1;
    end
endmodule

// file: design/vai_inserter.sv
/*
  Ancillary packet inserter in a 4:2:2 video word stream, with a two-entry
  output buffer. Assumes upstream marks the active part of field-blanking
  lines (anc) and the line number; all inputs are on clock_i.
*/
// How it works
// [R1] Each ancillary packet is preceded by zero, two all-ones, flag words.
// [R2] Flag value 15h means no further ancillary data on this line.
// [R3] Receivers treat any other flag as data directly after preamble.
// [R4] Insertion changes flag from 15h and appends a free preamble after.
// [R5] Non-preamble 8-bit words carry four Hamming (8,4) coded bits.
// [R6] Lines 20 and 333 stay reserved in 625-line mode.
// [R7] Optional header: three type words then two length words, coded.
// [R8] 10-bit header: ident, block, count with parities; checksum closes.
// [R9] Lines 23 and 623 stay reserved in 625 mode for aspect flag.
// [R10] Preamble found by zero, ones, ones on consecutive words, then flag.
// [R11] Insert only at free flag; never overwrite an existing packet.
`timescale 1ns/100ps
module vai_inserter
  import vai_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  input  wire vai_vid_s vid_i,
  input  wire logic     vid_valid_i,
  output logic          vid_ready_o,
  output vai_vid_s      vid_o,
  output logic          vid_valid_o,
  input  wire logic     vid_ready_i,
  input  wire logic [7:0] pay_i,
  input  wire logic     pay_valid_i,
  input  wire logic     pay_last_i,
  output logic          pay_ready_o,
  input  wire vai_hdr_s hdr_i,
  input  wire logic     hdr_en_i,
  input  wire logic     ten_bit_i,
  input  wire logic     mode625_i,
  output logic          busy_o
);

  function automatic logic [7:0] ham84(input logic [3:0] n);
    case (n)
      4'h0: ham84 = 8'h15;
      4'h1: ham84 = 8'h02;
      4'h2: ham84 = 8'h49;
      4'h3: ham84 = 8'h5e;
      4'h4: ham84 = 8'h64;
      4'h5: ham84 = 8'h73;
      4'h6: ham84 = 8'h38;
      4'h7: ham84 = 8'h2f;
      4'h8: ham84 = 8'hd0;
      4'h9: ham84 = 8'hc7;
      4'ha: ham84 = 8'h8c;
      4'hb: ham84 = 8'h9b;
      4'hc: ham84 = 8'ha1;
      4'hd: ham84 = 8'hb6;
      4'he: ham84 = 8'hfd;
      default: ham84 = 8'hea;
    endcase
  endfunction

  // Word for the 8-bit format: coded byte in the upper eight bits
  function automatic logic [9:0] w8(input logic [3:0] n);
    w8 = {ham84(n), 2'b00};
  endfunction

  // Bit 8 makes the low nine bits even, bit 9 is its complement
  function automatic logic [9:0] w10(input logic [7:0] b);
    w10 = {~(^b), ^b, b};
  endfunction

  vai_state_e  state_reg;
  logic [1:0]  det_cnt_reg;
  logic [2:0]  hdr_idx_reg;
  logic [1:0]  pre_idx_reg;
  logic [8:0]  sum_reg;
  vai_vid_s    buf_mem [VAI_BUF_DEPTH];
  logic        wr_ptr_reg;
  logic        rd_ptr_reg;
  logic [1:0]  cnt_reg;

  logic        room;
  logic        step;
  logic        pop;
  logic        reserved;
  logic        can_ins;
  logic        at_flag;
  logic [7:0]  in_hi;
  logic [9:0]  out_word;
  logic [9:0]  hdr_word;
  logic        start;
  logic        hdr_last;
  vai_state_e  state_next;
  vai_vid_s    out_vid;

  assign in_hi = vid_i.word[9:2];
  assign room = (cnt_reg != 2'(VAI_BUF_DEPTH));
  assign pop = vid_valid_o & vid_ready_i;
  // A data slot needs a payload byte; stalling the video keeps them aligned
  assign step = vid_valid_i & room & ((state_reg != VAI_ST_DATA) | pay_valid_i);
  assign vid_ready_o = room & ((state_reg != VAI_ST_DATA) | pay_valid_i);
  assign pay_ready_o = step & (state_reg == VAI_ST_DATA);
  assign busy_o = (state_reg != VAI_ST_SCAN);

  always_comb
  begin
    reserved = mode625_i &
      ((vid_i.line == VAI_LINE_EQP_A) | (vid_i.line == VAI_LINE_EQP_B)); // [R6]
    if (mode625_i & ((vid_i.line == VAI_LINE_ASP_A) |
                     (vid_i.line == VAI_LINE_ASP_B)))
    begin
      reserved = 1'b1; // [R9]
    end
  end

  assign can_ins = pay_valid_i & vid_i.anc & ~reserved;
  // Own appended preamble also offers its flag slot, so inserts chain
  assign at_flag = ((state_reg == VAI_ST_SCAN) & (det_cnt_reg == VAI_DET_FLAG)
                    & (in_hi == VAI_FLAG_FREE)) |
                   ((state_reg == VAI_ST_PRE) & (pre_idx_reg == VAI_PRE_FLAG));
  assign start = at_flag & can_ins; // [R11]
  assign hdr_last = ten_bit_i ? (hdr_idx_reg == VAI_HDR_LAST_10)
                              : (hdr_idx_reg == VAI_HDR_LAST_8);

  always_comb
  begin
    hdr_word = w8(hdr_i.typ[3:0]);
    if (ten_bit_i)
    begin
      case (hdr_idx_reg)
        3'd0: hdr_word = w10(hdr_i.ident); // [R8]
        3'd1: hdr_word = w10(hdr_i.blkno); // [R8]
        default: hdr_word = w10(hdr_i.len); // [R8]
      endcase
    end
    else
    begin
      case (hdr_idx_reg)
        3'd0: hdr_word = w8(hdr_i.typ[3:0]); // [R7]
        3'd1: hdr_word = w8(hdr_i.typ[7:4]); // [R7]
        3'd2: hdr_word = w8(hdr_i.typ[11:8]); // [R7]
        3'd3: hdr_word = w8(hdr_i.len[3:0]); // [R7]
        default: hdr_word = w8(hdr_i.len[7:4]); // [R7]
      endcase
    end
  end

  always_comb
  begin
    out_word = vid_i.word;
    state_next = state_reg;
    case (state_reg)
      VAI_ST_SCAN:
      begin
        if (start)
        begin
          out_word = w8(VAI_FLAG_BUSY); // [R4]
          state_next = hdr_en_i ? VAI_ST_HDR : VAI_ST_DATA;
        end
      end
      VAI_ST_HDR:
      begin
        out_word = hdr_word;
        if (hdr_last)
        begin
          state_next = VAI_ST_DATA;
        end
      end
      VAI_ST_DATA:
      begin
        out_word = ten_bit_i ? w10(pay_i) : w8(pay_i[3:0]); // [R5]
        if (pay_last_i)
        begin
          state_next = ten_bit_i ? VAI_ST_SUM : VAI_ST_PRE;
        end
      end
      VAI_ST_SUM:
      begin
        out_word = {~sum_reg[8], sum_reg}; // [R8]
        state_next = VAI_ST_PRE;
      end
      VAI_ST_PRE:
      begin
        case (pre_idx_reg)
          2'd0: out_word = {VAI_PRE_ZERO, 2'b00}; // [R1]
          2'd1: out_word = {VAI_PRE_ONES, 2'b00}; // [R1]
          2'd2: out_word = {VAI_PRE_ONES, 2'b00}; // [R1]
          default:
          begin
            if (start)
            begin
              out_word = w8(VAI_FLAG_BUSY); // [R4]
              state_next = hdr_en_i ? VAI_ST_HDR : VAI_ST_DATA;
            end
            else
            begin
              out_word = {VAI_FLAG_FREE, 2'b00}; // [R2] [R4]
              state_next = VAI_ST_SCAN;
            end
          end
        endcase
      end
      default: state_next = VAI_ST_SCAN;
    endcase
    out_vid = '{word: out_word, line: vid_i.line, anc: vid_i.anc};
  end

  // Sequencer; a packet must fit in the free tail of the line, not checked here: a started packet runs on past the end of anc
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= VAI_ST_SCAN;
    end
    else if (step)
    begin
      state_reg <= state_next;
    end
  end

  // Preamble detector on the incoming words
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      det_cnt_reg <= VAI_CNT_RST;
    end
    else if (step)
    begin
      if (!vid_i.anc || state_reg != VAI_ST_SCAN)
      begin
        det_cnt_reg <= VAI_CNT_RST;
      end
      else
      begin
        case (det_cnt_reg)
          2'd1: det_cnt_reg <= (in_hi == VAI_PRE_ONES) ? 2'd2
                : ((in_hi == VAI_PRE_ZERO) ? 2'd1 : 2'd0); // [R10]
          2'd2: det_cnt_reg <= (in_hi == VAI_PRE_ONES) ? 2'd3
                : ((in_hi == VAI_PRE_ZERO) ? 2'd1 : 2'd0); // [R10]
          2'd3: det_cnt_reg <= VAI_CNT_RST; // [R3]
          default: det_cnt_reg <= (in_hi == VAI_PRE_ZERO) ? 2'd1 : 2'd0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      hdr_idx_reg <= 3'd0;
      pre_idx_reg <= VAI_CNT_RST;
    end
    else if (step)
    begin
      hdr_idx_reg <= (state_reg == VAI_ST_HDR) ? hdr_idx_reg + 3'd1 : 3'd0;
      pre_idx_reg <= (state_reg == VAI_ST_PRE) ? pre_idx_reg + 2'd1
                                               : VAI_CNT_RST;
    end
  end

  // Checksum runs over header and payload words, nine bits wide
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sum_reg <= VAI_SUM_RST;
    end
    else if (step)
    begin
      if (start)
      begin
        sum_reg <= VAI_SUM_RST;
      end
      else if (state_reg == VAI_ST_HDR || state_reg == VAI_ST_DATA)
      begin
        sum_reg <= sum_reg + out_word[8:0]; // [R8]
      end
    end
  end

  // Two-entry output buffer so a stall downstream drops nothing
  always_ff @(posedge clock_i)
  begin
    if (step)
    begin
      buf_mem[wr_ptr_reg] <= out_vid;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end
    else
    begin
      if (step)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, step} - {1'b0, pop};
    end
  end

  assign vid_valid_o = (cnt_reg != 2'd0);
  assign vid_o = buf_mem[rd_ptr_reg];

endmodule

// file: design/vai_pkg.sv
/*
  Shared constants and carriers for the ancillary data inserter.
  Assumes a 10-bit video word stream; 8-bit words sit in bits 9..2.
*/
package vai_pkg;

  localparam logic [7:0] VAI_PRE_ZERO   = 8'h00;
  localparam logic [7:0] VAI_PRE_ONES   = 8'hff;
  localparam logic [7:0] VAI_FLAG_FREE  = 8'h15;
  localparam logic [3:0] VAI_FLAG_BUSY  = 4'h1;
  localparam logic [9:0] VAI_LINE_EQP_A = 10'd20;
  localparam logic [9:0] VAI_LINE_EQP_B = 10'd333;
  localparam logic [9:0] VAI_LINE_ASP_A = 10'd23;
  localparam logic [9:0] VAI_LINE_ASP_B = 10'd623;
  localparam logic [2:0] VAI_HDR_LAST_8  = 3'd4;
  localparam logic [2:0] VAI_HDR_LAST_10 = 3'd2;
  localparam logic [1:0] VAI_DET_FLAG   = 2'd3;
  localparam logic [1:0] VAI_PRE_FLAG   = 2'd3;
  localparam logic [1:0] VAI_CNT_RST    = 2'd0;
  localparam logic [8:0] VAI_SUM_RST    = 9'h000;
  localparam int         VAI_BUF_DEPTH  = 2;

  typedef enum logic [2:0] {
    VAI_ST_SCAN = 3'b000,
    VAI_ST_HDR  = 3'b001,
    VAI_ST_DATA = 3'b011,
    VAI_ST_SUM  = 3'b010,
    VAI_ST_PRE  = 3'b110
  } vai_state_e;

  typedef struct packed {
    logic [9:0] word;
    logic [9:0] line;
    logic       anc;
  } vai_vid_s;

  typedef struct packed {
    logic [11:0] typ;
    logic [7:0]  len;
    logic [7:0]  ident;
    logic [7:0]  blkno;
  } vai_hdr_s;

endpackage
